/* rtl/tgd_pkg.sv */
package tgd_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] TGD_SRC_OFFSET   = 8'h1c;
  localparam logic [7:0] TGD_SRC_RESET    = 8'h00;
  localparam int         TGD_BIT_ANY      = 6;
  localparam int         TGD_BIT_SINGLE   = 5;
  localparam int         TGD_BIT_DOUBLE   = 4;
  localparam int         TGD_BIT_SIGN     = 3;
  localparam int         TGD_BIT_X        = 2;
  localparam int         TGD_BIT_Y        = 1;
  localparam int         TGD_BIT_Z        = 0;

  // ------------------------------------------------------------
  // sample and threshold scaling
  // ------------------------------------------------------------
  localparam int         TGD_SAMPLE_W     = 16;
  localparam int         TGD_THS_SHIFT    = 10;

  // ------------------------------------------------------------
  // window lengths in sample periods
  // ------------------------------------------------------------
  localparam int         TGD_CNT_W        = 9;
  localparam logic [8:0] TGD_SHOCK_ZERO   = 9'h004;
  localparam int         TGD_SHOCK_SHIFT  = 3;
  localparam logic [8:0] TGD_QUIET_ZERO   = 9'h002;
  localparam int         TGD_QUIET_SHIFT  = 2;
  localparam logic [8:0] TGD_GAP_ZERO     = 9'h010;
  localparam int         TGD_GAP_SHIFT    = 5;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } tgd_axes_t;

  typedef struct packed {
    logic [2:0] axis_en;
    logic [4:0] hit_threshold_field;
    logic [1:0] shock;
    logic [1:0] quiet;
    logic [3:0] gap_window_len;
    logic       double_en;
    logic       latch_request_enable;
    logic       pin1_single_route;
    logic       pin1_double_route;
    logic       pin2_single_route;
    logic       pin2_double_route;
  } tgd_cfg_t;

  typedef enum logic [2:0] {
    TGD_IDLE,
    TGD_SHOCK1,
    TGD_QUIET,
    TGD_GAP,
    TGD_SHOCK2,
    TGD_SETTLE
  } tgd_state_t;

endpackage : tgd_pkg

/* rtl/tgd_tap_detector.sv */
// How it works
// - slope per axis is current sample minus previous, halved.
// - a tap is a threshold excursion that ends within the shock window.
// - without latching, requests pulse for the quiet window length.
// - latching holds single or double request by double enable until read.
// - latching with no pin route behaves as unlatched.
// - double enable 0 gives single taps only; 1 gives both kinds.
// - second tap must start after quiet and before the gap window ends.
// - second excursion must also end within the shock window.
// - with double enable set, any excursion during quiet after the first tap kills the sequence.
// - gap window starts right after the first quiet window.
// - only axes with their enable bit set take part.
// - magnitude of either sign against a 5-bit threshold of full scale/32.
// - shock window is 4 samples at 0, else n times 8.
// - quiet window is 2 samples at 0, else n times 4.
// - gap window is 16 samples at 0, else n times 32.
// - route bits steer single and double requests to either pin.
// - no tap request while the accelerometer is inactive.
// - source bit 7 reads 0; bits 6,5,4 any, single, double flags.
// - bit 3 gives the tap sign, 1 for negative.
// - bits 2,1,0 flag the x, y, z axis of the tap.
// - inactivity comes from the wake logic, sampling then at 13 Hz.
`timescale 1ns/1ps
`default_nettype none

module tgd_tap_detector (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // accelerometer samples
  input  wire logic              sample_stb_i,
  input  wire tgd_pkg::tgd_axes_t accel_i,
  input  wire logic              inactive_i,
  // configuration bits
  input  wire tgd_pkg::tgd_cfg_t cfg_i,
  // source register read
  input  wire logic              src_rd_i,
  output logic [7:0]             tap_event_source_o,
  // interrupt pins
  output logic                   irq_pin_one_o,
  output logic                   irq_pin_two_o
);
  import tgd_pkg::*;

  // ------------------------------------------------------------
  // slope and threshold
  // ------------------------------------------------------------
  tgd_axes_t  prev_q;
  logic [2:0] over_ax;
  logic [2:0] neg_ax;
  logic [16:0] ths_w;

  assign ths_w = 17'(cfg_i.hit_threshold_field) << TGD_THS_SHIFT;

  // the first sample after reset is differenced against zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prev_q <= '0;
    end else if (sample_stb_i) begin
      prev_q <= accel_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      // slice g is z at 0 up to x at 2, so the enable bit is mirrored
      logic signed [15:0] cur_w;
      logic signed [15:0] old_w;
      logic signed [16:0] diff_w;
      logic signed [16:0] slope_w;
      logic        [16:0] mag_w;
      assign cur_w   = accel_i[g*16 +: 16];
      assign old_w   = prev_q[g*16 +: 16];
      // signed operands, so negative samples sign-extend
      assign diff_w  = 17'(cur_w) - 17'(old_w);
      assign slope_w = diff_w >>> 1;
      assign mag_w   = slope_w[16] ? 17'(-slope_w) : 17'(slope_w);
      // strict: a slope equal to the threshold is not over
      assign over_ax[g] = cfg_i.axis_en[2-g] && (mag_w > ths_w);
      assign neg_ax[g]  = slope_w[16];
    end
  endgenerate

  logic over;
  assign over = |over_ax;

  // ------------------------------------------------------------
  // window lengths
  // ------------------------------------------------------------
  logic [8:0] shock_len;
  logic [8:0] quiet_len;
  logic [8:0] gap_len;

  // windows count strobes, so they scale with any sample rate
  assign shock_len = (cfg_i.shock == 2'h0) ? TGD_SHOCK_ZERO
                   : 9'(cfg_i.shock) << TGD_SHOCK_SHIFT;
  assign quiet_len = (cfg_i.quiet == 2'h0) ? TGD_QUIET_ZERO
                   : 9'(cfg_i.quiet) << TGD_QUIET_SHIFT;
  assign gap_len   = (cfg_i.gap_window_len == 4'h0) ? TGD_GAP_ZERO
                   : 9'(cfg_i.gap_window_len) << TGD_GAP_SHIFT;

  // ------------------------------------------------------------
  // tap sequencer
  // ------------------------------------------------------------
  tgd_state_t state_q;
  logic [8:0] cnt_q;
  logic [2:0] axis_q;
  logic       sign_q;
  logic       single_ev;
  logic       double_ev;

  // axis and sign captured at the start of an excursion, x first
  logic [2:0] first_ax;
  logic       first_neg;
  always_comb begin
    first_ax  = 3'h0;
    first_neg = 1'b0;
    if (over_ax[TGD_BIT_X]) begin
      first_ax  = 3'h4;
      first_neg = neg_ax[TGD_BIT_X];
    end else if (over_ax[TGD_BIT_Y]) begin
      first_ax  = 3'h2;
      first_neg = neg_ax[TGD_BIT_Y];
    end else if (over_ax[TGD_BIT_Z]) begin
      first_ax  = 3'h1;
      first_neg = neg_ax[TGD_BIT_Z];
    end
  end

  // ------------------------------------------------------------
  // event strobes
  // ------------------------------------------------------------
  // inactivity blocks every event, pulses and flags alike
  logic ev_ok;
  assign ev_ok     = sample_stb_i && !inactive_i && !over;
  assign single_ev = ev_ok && (state_q == TGD_SHOCK1);
  assign double_ev = ev_ok && (state_q == TGD_SHOCK2)
                   && cfg_i.double_en;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= TGD_IDLE;
      cnt_q   <= '0;
    end else if (sample_stb_i) begin
      cnt_q <= cnt_q + 9'h001;
      case (state_q)
        TGD_IDLE: begin
          if (over) begin
            state_q <= TGD_SHOCK1;
            cnt_q   <= 9'h001;
          end
        end
        TGD_SHOCK1: begin
          if (!over) begin
            state_q <= TGD_QUIET;
            cnt_q   <= 9'h001;
          end else if (cnt_q >= shock_len) begin
            state_q <= TGD_SETTLE;
          end
        end
        TGD_QUIET: begin
          if (cfg_i.double_en && over) begin
            state_q <= TGD_SETTLE;
          end else if (cnt_q >= quiet_len) begin
            state_q <= cfg_i.double_en ? TGD_GAP : TGD_IDLE;
            cnt_q   <= 9'h001;
          end
        end
        TGD_GAP: begin
          if (over) begin
            state_q <= TGD_SHOCK2;
            cnt_q   <= 9'h001;
          end else if (cnt_q >= gap_len) begin
            state_q <= TGD_IDLE;
          end
        end
        TGD_SHOCK2: begin
          if (!over) begin
            state_q <= TGD_IDLE;
          end else if (cnt_q >= shock_len) begin
            state_q <= TGD_SETTLE;
          end
        end
        TGD_SETTLE: begin
          // a long excursion must end before a new tap may start
          if (!over) begin
            state_q <= TGD_IDLE;
          end
        end
        default: state_q <= TGD_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // axis and sign capture
  // ------------------------------------------------------------
  // the axis that opens an excursion is kept, even if others join later
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      axis_q <= '0;
      sign_q <= 1'b0;
    end else if (sample_stb_i && over
                 && ((state_q == TGD_IDLE) || (state_q == TGD_GAP))) begin
      axis_q <= first_ax;
      sign_q <= first_neg;
    end
  end

  // ------------------------------------------------------------
  // request pulses, one quiet window long
  // ------------------------------------------------------------
  logic       pulse_s_q;
  logic       pulse_d_q;
  logic [8:0] pcnt_q;

  // a new event restarts the pulse and drops the other kind
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pulse_s_q <= 1'b0;
      pulse_d_q <= 1'b0;
      pcnt_q    <= '0;
    end else if (single_ev || double_ev) begin
      pulse_s_q <= single_ev;
      pulse_d_q <= double_ev;
      pcnt_q    <= 9'h000;
    end else if (sample_stb_i && (pulse_s_q || pulse_d_q)) begin
      pcnt_q <= pcnt_q + 9'h001;
      if (pcnt_q + 9'h001 >= quiet_len) begin
        pulse_s_q <= 1'b0;
        pulse_d_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // latched request
  // ------------------------------------------------------------
  logic latch_on;
  logic latch_ev;
  logic lat_q;

  // latching only counts when the latched kind reaches a pin
  assign latch_on = cfg_i.latch_request_enable && (cfg_i.double_en
                  ? (cfg_i.pin1_double_route || cfg_i.pin2_double_route)
                  : (cfg_i.pin1_single_route || cfg_i.pin2_single_route));
  assign latch_ev = cfg_i.double_en ? double_ev : single_ev;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lat_q <= 1'b0;
    end else begin
      lat_q <= (latch_on && latch_ev) || (lat_q && !src_rd_i);
    end
  end

  // the kind that is not latched keeps pulsing
  logic single_req;
  logic double_req;
  assign single_req = (latch_on && !cfg_i.double_en) ? lat_q : pulse_s_q;
  assign double_req = (latch_on && cfg_i.double_en) ? lat_q : pulse_d_q;

  // ------------------------------------------------------------
  // interrupt pins
  // ------------------------------------------------------------
  // pins are combinational so a route change shows at once
  assign irq_pin_one_o = (cfg_i.pin1_single_route && single_req)
                       || (cfg_i.pin1_double_route && double_req);
  assign irq_pin_two_o = (cfg_i.pin2_single_route && single_req)
                       || (cfg_i.pin2_double_route && double_req);

  // ------------------------------------------------------------
  // source register
  // ------------------------------------------------------------
  logic [7:0] src_q;
  logic       any_ev;
  assign any_ev = single_ev || double_ev;

  // a new event in the read cycle wins over the clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      src_q <= TGD_SRC_RESET;
    end else if (any_ev) begin
      src_q[7]              <= 1'b0;
      src_q[TGD_BIT_ANY]    <= 1'b1;
      src_q[TGD_BIT_SINGLE] <= single_ev || (src_q[TGD_BIT_SINGLE] && !src_rd_i);
      src_q[TGD_BIT_DOUBLE] <= double_ev || (src_q[TGD_BIT_DOUBLE] && !src_rd_i);
      src_q[TGD_BIT_SIGN]   <= sign_q;
      src_q[TGD_BIT_X:0]    <= axis_q;
    end else if (src_rd_i) begin
      src_q <= TGD_SRC_RESET;
    end
  end

  assign tap_event_source_o = src_q;

endmodule : tgd_tap_detector

`default_nettype wire

/* sim/tgd_chk_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module tgd_chk (
  // clock, reset, stimulus
  input wire logic               mclk_i,
  input wire logic               rst_i,
  input wire logic               sample_stb_i,
  input wire tgd_pkg::tgd_axes_t accel_i,
  input wire logic               inactive_i,
  input wire tgd_pkg::tgd_cfg_t  cfg_i,
  input wire logic               src_rd_i,
  // watched outputs
  input wire logic [7:0]         tap_event_source_o,
  input wire logic               irq_pin_one_o,
  input wire logic               irq_pin_two_o
);
  import tgd_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ----
  // watched relations
  // ----
  wire logic [7:0] s  = tap_event_source_o;
  // single-mode latch toward pin one; double never fires here
  wire logic       l1 = cfg_i.latch_request_enable && !cfg_i.double_en && cfg_i.pin1_single_route;
  sequence s_clr; src_rd_i && !sample_stb_i; endsequence
  sequence s_l1clr; l1 && src_rd_i && !sample_stb_i; endsequence
  property p_b7; s[7] == 1'b0; endproperty
  a_b7: assert property (p_b7) else $error("bit 7 set");
  property p_clr; s_clr |=> s == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("read left flags");
  property p_idle; inactive_i |=> !$rose(s[6]) && !$rose(irq_pin_one_o); endproperty
  a_idle: assert property (p_idle) else $error("tap while inactive");
  property p_single; !cfg_i.double_en && !$past(cfg_i.double_en) |-> !$rose(s[4]); endproperty
  a_single: assert property (p_single) else $error("double in single mode");
  property p_axis;
    $rose(s[6]) |-> (s[5] || s[4]) && $onehot(s[2:0])
      && (s[2:0] & ~{cfg_i.axis_en[0], cfg_i.axis_en[1], cfg_i.axis_en[2]}) == 3'h0;
  endproperty
  a_axis: assert property (p_axis) else $error("bad axis flags");
  property p_when; $changed(s) |-> $past(sample_stb_i) || $past(src_rd_i); endproperty
  a_when: assert property (p_when) else $error("flags moved off strobe");
  property p_route1;
    $rose(irq_pin_one_o) |-> $past(sample_stb_i) && (cfg_i.pin1_single_route || cfg_i.pin1_double_route);
  endproperty
  a_route1: assert property (p_route1) else $error("pin one unrouted");
  property p_hold; l1 && irq_pin_one_o && !src_rd_i |=> irq_pin_one_o; endproperty
  a_hold: assert property (p_hold) else $error("latch dropped");
  property p_drop; s_l1clr |=> !irq_pin_one_o; endproperty
  a_drop: assert property (p_drop) else $error("latch kept after read");
endmodule : tgd_chk
bind tgd_tap_detector tgd_chk u_chk (.mclk_i, .rst_i, .sample_stb_i, .accel_i, .inactive_i, .cfg_i,
  .src_rd_i, .tap_event_source_o, .irq_pin_one_o, .irq_pin_two_o);
`default_nettype wire

/* sim/tgd_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tgd_host (
  // clock and source value
  input  wire logic       mclk_i,
  input  wire logic [7:0] tap_event_source_i,
  // read strobe
  output logic            src_rd_o
);
  // ----
  // host read cycle
  // ----
  initial src_rd_o = 1'b0;
  // value is taken at the read edge, before the clear lands
  task automatic read_src(output logic [7:0] v);
    @(negedge mclk_i);
    src_rd_o = 1'b1;
    @(posedge mclk_i);
    v = tap_event_source_i;
    @(negedge mclk_i);
    src_rd_o = 1'b0;
  endtask : read_src
endmodule : tgd_host
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tgd_pkg::*;
  logic       mclk_i, rst_i, stb, inact;
  tgd_axes_t  a;
  tgd_cfg_t   cfg;
  wire logic  rd, p1, p2;
  wire logic [7:0] src;
  logic [7:0] v;
  int         error_cnt, tests_run, cyc, n;
  tgd_tap_detector dut (.mclk_i(mclk_i), .rst_i(rst_i), .sample_stb_i(stb), .accel_i(a), .inactive_i(inact),
    .cfg_i(cfg), .src_rd_i(rd), .tap_event_source_o(src), .irq_pin_one_o(p1), .irq_pin_two_o(p2));
  tgd_host host (.mclk_i(mclk_i), .tap_event_source_i(src), .src_rd_o(rd));
  // ----
  // clock, timeout, tasks
  // ----
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // strobe every other cycle; real hosts pick a slower rate
  task automatic smp(input int dx, input int dy, input int dz);
    @(negedge mclk_i);
    a.x = a.x + 16'(dx);
    a.y = a.y + 16'(dy);
    a.z = a.z + 16'(dz);
    stb = 1'b1;
    @(negedge mclk_i);
    stb = 1'b0;
  endtask : smp
  // step then hold: one slope over threshold, then zero slope
  task automatic tap(input int dx, input int dy);
    smp(dx, dy, 0);
    smp(0, 0, 0);
  endtask : tap
  task automatic steady(input int k);
    repeat (k) smp(0, 0, 0);
  endtask : steady
  task automatic rd_chk(input logic [7:0] exp, input logic [7:0] m);
    host.read_src(v);
    chk(v & m, exp);
  endtask : rd_chk
  // ----
  // scenarios
  // ----
  initial begin
    error_cnt = 0;
    tests_run = 0;
    stb = 1'b0;
    inact = 1'b0;
    a = '0;
    cfg = '0;
    cfg.axis_en = 3'h7;
    cfg.hit_threshold_field = 5'h01; // slope must exceed 1024
    cfg.quiet = 2'h1;
    cfg.pin1_single_route = 1'b1;
    rst_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    rst_i = 1'b0;
    chk(src, 8'h00);
    tap(2500, 0);
    chk(src, 8'h64);
    n = 0;
    while (p1 === 1'b1 && n < 20) begin
      smp(0, 0, 0);
      n++;
    end
    chk(8'(n), 8'h04);
    chk({7'h0, p2}, 8'h00);
    rd_chk(8'h64, 8'hff);
    chk(src, 8'h00);
    cfg.axis_en = 3'h6;
    tap(2500, -2500);
    chk(src, 8'h6a);
    rd_chk(8'h6a, 8'hff);
    steady(6);
    cfg.axis_en = 3'h7;
    cfg.shock = 2'h0;
    repeat (5) smp(2500, 0, 0);
    smp(0, 0, 0);
    chk(src, 8'h00);
    smp(2500, 0, 0);
    tap(2500, 0);
    chk(src, 8'h64);
    rd_chk(8'h64, 8'hff);
    steady(6);
    // eight samples over still make a tap with shock set to one
    cfg.shock = 2'h1;
    repeat (8) smp(-2500, 0, 0);
    smp(0, 0, 0);
    chk(src, 8'h6c);
    rd_chk(8'h6c, 8'hff);
    steady(6);
    cfg.shock = 2'h0;
    inact = 1'b1;
    tap(-2500, 0);
    chk({src[6:0], p1}, 8'h00);
    inact = 1'b0;
    steady(6);
    cfg.latch_request_enable = 1'b1;
    tap(-2500, 0);
    steady(8);
    chk({7'h0, p1}, 8'h01);
    rd_chk(8'h6c, 8'hff);
    chk({7'h0, p1}, 8'h00);
    // double, latched on pin two; second over lands late in the gap
    cfg.double_en = 1'b1;
    cfg.quiet = 2'h0;
    cfg.gap_window_len = 4'h0;
    cfg.pin2_double_route = 1'b1;
    tap(-2500, 0);
    steady(15);
    tap(-2500, 0);
    chk(src & 8'h50, 8'h50);
    steady(10);
    chk({7'h0, p2}, 8'h01);
    rd_chk(8'h50, 8'h50);
    chk({7'h0, p2}, 8'h00);
    // an over in quiet must keep a later tap from pairing as a double
    tap(-2500, 0);
    tap(-2500, 0);
    steady(2);
    tap(-2500, 0);
    steady(20);
    chk(src & 8'h10, 8'h00);
    rd_chk(8'h00, 8'h10);
    tap(-2500, 0);
    steady(22);
    tap(-2500, 0);
    chk(src & 8'h10, 8'h00);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
